// *** sim/modbus_master_model.sv ***
// MODBUS master model: sends request frames and gathers reply bytes
`default_nettype none
module modbus_master_model
  import modbus_pkg::*;
(
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxEnd,
  output logic tcpMode
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] reply[$];

  function automatic logic [15:0] crc16(input byte unsigned f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ 16'(f[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  initial begin
    rxData = 8'h00;
    rxValid = 1'h0;
    rxEnd = 1'h0;
    tcpMode = 1'h0;
    txReady = 1'h1;
  end

  // A corrupt check byte is the only fault this task adds itself, and only to serial frames
  task automatic send(input byte unsigned f[$], input bit tcp, input bit bad);
    logic [15:0] c;
    c = crc16(f);
    if (!tcp) begin
      f.push_back(c[7:0]);
      f.push_back(c[15:8] ^ {7'h00, bad});
    end
    foreach (f[i]) begin
      @(posedge core_clk);
      tcpMode <= tcp;
      rxData <= f[i];
      rxValid <= 1'h1;
      rxEnd <= (i == f.size() - 1);
    end
    @(posedge core_clk);
    rxValid <= 1'h0;
    rxEnd <= 1'h0;
    // Idle line shows the inverse so a stale byte cannot pass as fresh
    rxData <= ~rxData;
  endtask : send

  always @(posedge core_clk) begin
    if (txValid && txReady)
      reply.push_back(txData);
    txReady <= slow ? 1'($urandom_range(1)) : 1'h1;
  end
endmodule : modbus_master_model
`default_nettype wire

// *** sim/modbus_slave_request_handler_tb.sv ***
// Self-checking bench for the MODBUS request handler
`default_nettype none
module modbus_slave_request_handler_tb
  import modbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] slaveId = 8'h11;
  logic [2:0] baudSel = 3'h0;
  logic baudLoad = 1'h0;
  logic [15:0] relayStatus = 16'h0000;
  logic [7:0] excStatus = 8'h00;
  logic [31:0] valWord;
  logic slow = 1'h0;
  logic mode = 1'h0;
  logic [7:0] rxData;
  logic rxValid;
  logic rxEnd;
  logic tcpMode;
  logic txReady;
  logic [7:0] txData;
  logic txValid;
  logic [VAL_IDX_W-1:0] valIdx;
  logic coilPulse;
  logic [15:0] coilAddr;
  logic coilOn;
  logic [15:0] baudDiv;
  logic [3:0] charLen;
  logic [15:0] tcpPort;
  logic [15:0] lastCoilAddr = 16'h0000;
  logic lastCoilOn = 1'h0;
  int coilCount = 0;
  int failures = 0;
  int cmpCount = 0;
  int cycles = 0;
  int rates[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  byte unsigned fcs[6] = '{1, 2, 3, 4, 5, 7};

  modbus_request_handler dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .rxData(rxData), .rxValid(rxValid),
    .rxEnd(rxEnd), .tcpMode(tcpMode), .slaveId(slaveId), .baudSel(baudSel),
    .baudLoad(baudLoad), .relayStatus(relayStatus), .excStatus(excStatus),
    .valWord(valWord), .txReady(txReady), .txData(txData), .txValid(txValid),
    .valIdx(valIdx), .coilPulse(coilPulse), .coilAddr(coilAddr), .coilOn(coilOn),
    .baudDiv(baudDiv), .charLen(charLen), .tcpPort(tcpPort)
  );

  modbus_master_model master (
    .core_clk(core_clk), .slow(slow), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd),
    .tcpMode(tcpMode)
  );

  always #50 core_clk = ~core_clk;

  // Halves differ so a swapped register order shows up
  function automatic logic [31:0] valOf(input logic [6:0] i);
    return {1'h1, i, 1'h0, ~i, 8'hA5, 1'h0, i};
  endfunction : valOf

  // Value source answers in the same cycle: the latch stage samples it one edge after the index
  always_comb valWord = valOf(valIdx);

  task automatic results();
    $display("comparisons %0d failures %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (coilPulse) begin
      coilCount <= coilCount + 1;
      lastCoilAddr <= coilAddr;
      lastCoilOn <= coilOn;
    end
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic run(input bit tcp, input logic [7:0] adr, input bit bad,
                     input byte unsigned pdu[$]);
    byte unsigned f[$];
    byte unsigned b[$];
    byte unsigned e[$];
    int a = 0;
    int q = 0;
    int x = 0;
    int k;
    int p;
    int n;
    logic [31:0] w;
    logic [15:0] t;
    if (pdu.size() == 5) begin
      a = {pdu[1], pdu[2]};
      q = {pdu[3], pdu[4]};
    end
    case (pdu[0])
      1, 2: begin
        if (q == 0 || q > 16) x = 3;
        else if (a + q > 16) x = 2;
        n = (relayStatus >> a) & ((1 << q) - 1);
        b = {pdu[0], 8'((q + 7) / 8)};
        for (int i = 0; i < (q + 7) / 8; i++) b.push_back(8'(n >> (8 * i)));
      end
      3, 4: begin
        if (q == 0 || q > 125) x = 3;
        else if (a + q > 86) x = 2;
        b = {pdu[0], 8'(2 * q)};
        for (int r = a; r < a + q; r++) begin
          w = valOf(7'(r >> 1));
          t = r[0] ? w[31:16] : w[15:0];
          b = {b, t[15:8], t[7:0]};
        end
      end
      5: b = pdu;
      7: b = {pdu[0], excStatus};
      default: x = 1;
    endcase
    if (x != 0) b = {pdu[0] | 8'h80, 8'(x)};
    if (tcp) begin
      adr = 8'($urandom);
      t = 16'($urandom);
      f = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'(pdu.size() + 1), adr, pdu};
      e = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'(b.size() + 1), adr, b};
    end else begin
      f = {adr, pdu};
      e = {adr, b};
      t = master.crc16(e);
      e = {e, t[7:0], t[15:8]};
      if (bad || adr != slaveId || adr == 8'h00 || slaveId > 8'h7F) e = {};
    end
    // Frames longer than the receive store overrun it and are dropped
    if (f.size() + (tcp ? 0 : 2) > 16) e = {};
    p = (pdu[0] == 5 && (q == 16'hFF00 || q == 0) && e.size() > 0);
    k = coilCount;
    master.send(f, tcp, bad);
    for (n = 0; n < 600 && master.reply.size() < e.size(); n++) @(posedge core_clk);
    repeat (30) @(posedge core_clk);
    check(master.reply.size(), e.size(), "reply length");
    foreach (e[i]) if (i < master.reply.size()) check(master.reply[i], e[i], "byte");
    check(coilCount, k + p, "coil pulses");
    if (p) begin
      check(lastCoilAddr, a, "coil address");
      check(lastCoilOn, q != 0, "coil state");
    end
    master.reply.delete();
  endtask : run

  task automatic req(input byte unsigned p[$]);
    run(mode, slaveId, 1'h0, p);
  endtask : req

  initial begin
    void'($urandom(38));
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    check(baudDiv, CLK_HZ / 9600, "reset rate");
    check(charLen, 10, "char length");
    check(tcpPort, 502, "tcp port");
    foreach (rates[i]) begin
      baudSel <= 3'(i);
      baudLoad <= 1'h1;
      @(posedge core_clk);
      baudLoad <= 1'h0;
      @(posedge core_clk);
      check(baudDiv, CLK_HZ / rates[i], "rate divider");
    end
    relayStatus <= 16'hA59C;
    excStatus <= 8'h3C;
    @(posedge core_clk);
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      req({1, 0, 2, 0, 13});
      req({2, 0, 0, 0, 16});
      req({1, 0, 10, 0, 8});
      req({2, 0, 0, 0, 0});
      req({3, 0, 9, 0, 4});
      req({4, 0, 84, 0, 2});
      req({3, 0, 85, 0, 2});
      req({4, 0, 0, 0, 126});
      req({5, 0, 5, 8'hFF, 0});
      req({5, 0, 9, 0, 0});
      req({5, 0, 7, 8'h12, 8'h34});
      req({7});
      req({6, 0, 0, 0, 1});
    end
    slow <= 1'h1;
    repeat (12) begin
      relayStatus <= 16'($urandom);
      excStatus <= 8'($urandom);
      mode = 1'($urandom);
      @(posedge core_clk);
      req({fcs[$urandom_range(5)], 0, 8'($urandom_range(15)), 0,
           8'($urandom_range(6, 1))});
    end
    slow <= 1'h0;
    run(1'h0, slaveId, 1'h1, {3, 0, 0, 0, 1});
    run(1'h0, 8'h00, 1'h0, {3, 0, 0, 0, 1});
    run(1'h0, 8'h12, 1'h0, {3, 0, 0, 0, 1});
    run(1'h0, slaveId, 1'h0, {3, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    slaveId <= 8'h80;
    @(posedge core_clk);
    run(1'h0, 8'h80, 1'h0, {3, 0, 0, 0, 1});
    results();
  end
endmodule : modbus_slave_request_handler_tb
`default_nettype wire

// *** verilog/crc16_rtu.sv ***
// Byte-serial CRC-16 engine for serial frames
`default_nettype none
module crc16_rtu
  import modbus_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic crcClr,
  input wire logic crcEn,
  input wire logic [7:0] crcByte,
  output logic [15:0] crcOut
);
  typedef struct packed {
    logic [15:0] crc;
  } crc_state_t;

  crc_state_t cur;
  crc_state_t nxt;

  always_comb begin
    logic [15:0] c;
    c = cur.crc ^ {8'h00, crcByte};
    for (int i = 0; i < CHAR_DATA_BITS; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    nxt = cur;
    if (crcClr) nxt.crc = CRC_INIT;
    else if (crcEn) nxt.crc = c;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) cur <= '{crc: CRC_INIT};
    else cur <= nxt;
  end

  assign crcOut = cur.crc;
endmodule : crc16_rtu
`default_nettype wire

// *** verilog/modbus_pkg.sv ***
// Constants, types and reset image for the MODBUS request handler
// Operation
// - Serial characters are eight data bits, one stop bit, no parity.
// - Rates 1200 to 115200 baud selectable; reset selects 9600 baud.
// - TCP service listens on port 502 with the serial register map.
// - Serial frames answered only when address equals configured id 1..127.
// - Broadcast address zero ignored; identifiers 128..247 unsupported.
// - TCP frames have no address; unit id never gates the reply.
// - Parse seven-byte TCP header; echo transaction id and unit id.
// - Accept function codes 1, 2, 3, 4, 5 and 7 only.
// - Unsupported function code answered with illegal-function exception.
// - Serial frames end with a 16-bit CRC; TCP frames carry none.
// - Serial: address, function, data, check. TCP: header, function, data.
// - Read coils and read inputs both return output relay status.
// - Bit read carries start address and quantity; addresses are zero-based.
// - One bit per output from bit zero upward; unused high bits zero.
// - Bit-read byte count is quantity divided by eight, rounded up.
// - Exception codes: 1 function, 2 address, 3 data, 4 device failure.
// - Exception reply returns function code with top bit set, then code.
// - Holding and input register reads return same contiguous 16-bit registers.
// - Each value is a float in two registers, lower register less significant.
// - Registers sent high byte first; byte count twice the register quantity.
// - Register number one maps to address zero when decoding start address.
// - Coil write 0xFF00 on, 0x0000 off, others no effect; reply echoes.
`default_nettype none
package modbus_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CHAR_DATA_BITS = 8;
  localparam int unsigned CHAR_STOP_BITS = 1;
  localparam int unsigned CHAR_PARITY_BITS = 0;
  localparam int unsigned CHAR_START_BITS = 1;
  localparam logic [3:0] CHAR_LEN =
    4'(CHAR_START_BITS + CHAR_DATA_BITS + CHAR_PARITY_BITS + CHAR_STOP_BITS);

  localparam logic [2:0] BAUD_CODE_DEFAULT = 3'h3;

  function automatic int unsigned baud_rate(input logic [2:0] code);
    case (code)
      3'h0: return 1200;
      3'h1: return 2400;
      3'h2: return 4800;
      3'h3: return 9600;
      3'h4: return 19200;
      3'h5: return 38400;
      3'h6: return 57600;
      default: return 115200;
    endcase
  endfunction : baud_rate

  function automatic logic [15:0] baud_div(input logic [2:0] code);
    return 16'(CLK_HZ / baud_rate(code));
  endfunction : baud_div

  localparam logic [15:0] BAUD_DIV_DEFAULT = baud_div(BAUD_CODE_DEFAULT);
  localparam logic [15:0] TCP_PORT = 16'h01F6;

  localparam logic [7:0] BROADCAST_ID = 8'h00;
  localparam logic [7:0] SLAVE_ID_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ID_MAX = 8'h7F;

  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_INPUTS = 8'h02;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INREG = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_EXC_STATUS = 8'h07;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_DATA = 8'h03;
  localparam logic [7:0] EXC_DEV_FAIL = 8'h04;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  localparam logic [3:0] RTU_ADDR = 4'h0;
  localparam logic [3:0] RTU_HDR_LEN = 4'h1;
  localparam logic [3:0] MBAP_LEN = 4'h7;
  localparam logic [3:0] MBAP_PROTO_HI = 4'h2;
  localparam logic [3:0] MBAP_PROTO_LO = 4'h3;
  localparam logic [3:0] MBAP_LEN_HI = 4'h4;
  localparam logic [3:0] MBAP_LEN_LO = 4'h5;
  localparam logic [15:0] MBAP_PROTO = 16'h0000;
  localparam logic [15:0] MBAP_UNIT_LEN = 16'h0001;
  localparam logic [3:0] PDU_FC = 4'h0;
  localparam logic [3:0] PDU_ADDR_HI = 4'h1;
  localparam logic [3:0] PDU_ADDR_LO = 4'h2;
  localparam logic [3:0] PDU_QTY_HI = 4'h3;
  localparam logic [3:0] PDU_QTY_LO = 4'h4;
  localparam logic [4:0] PDU_REQ_LEN = 5'h05;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  localparam logic [4:0] RTU_MIN_CNT = 5'h04;
  localparam logic [4:0] TCP_MIN_CNT = 5'h08;
  localparam logic [4:0] BUF_BYTES = 5'h10;

  localparam logic [8:0] RSP_FC = 9'h000;
  localparam logic [8:0] RSP_COUNT = 9'h001;
  localparam logic [8:0] RSP_DATA = 9'h002;
  localparam logic [7:0] RSP_SHORT_LEN = 8'h02;
  localparam logic [7:0] COIL_RSP_LEN = 8'h05;
  localparam logic [4:0] BIT_ROUND = 5'h07;
  localparam int unsigned BIT_SHIFT = 3;
  localparam logic [15:0] STATUS_BITS = 16'h0010;
  localparam logic [15:0] REG_QTY_MAX = 16'h007D;
  localparam logic [16:0] REG_COUNT = 17'h00056;
  localparam int unsigned VAL_IDX_W = 7;

  typedef enum logic [4:0] {
    ST_RECV = 5'h01,
    ST_EVAL = 5'h02,
    ST_FETCH = 5'h04,
    ST_LATCH = 5'h08,
    ST_SEND = 5'h10
  } state_t;

  typedef struct packed {
    state_t st;
    logic [15:0][7:0] rxBuf;
    logic [4:0] rxCnt;
    logic rxOvf;
    logic tcp;
    logic [7:0] fc;
    logic [15:0] startA;
    logic [7:0] qty;
    logic [7:0] exc;
    logic [7:0] bodyLen;
    logic [15:0] bits;
    logic [8:0] pos;
    logic wordOk;
    logic halfHi;
    logic [15:0] word;
    logic [7:0] txData;
    logic txValid;
    logic [VAL_IDX_W-1:0] valIdx;
    logic coilPulse;
    logic [15:0] coilAddr;
    logic coilOn;
    logic [15:0] baudDiv;
    logic [3:0] charLen;
    logic [15:0] port;
  } core_t;

  localparam core_t CORE_RESET = '{
    st: ST_RECV,
    baudDiv: BAUD_DIV_DEFAULT,
    charLen: CHAR_LEN,
    port: TCP_PORT,
    default: '0
  };
endpackage : modbus_pkg
`default_nettype wire

// *** verilog/modbus_request_handler.sv ***
// MODBUS RTU and TCP request handler: frame check, decode and reply
`default_nettype none
module modbus_request_handler
  import modbus_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxEnd,
  input wire logic tcpMode,
  input wire logic [7:0] slaveId,
  input wire logic [2:0] baudSel,
  input wire logic baudLoad,
  input wire logic [15:0] relayStatus,
  input wire logic [7:0] excStatus,
  input wire logic [31:0] valWord,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic txValid,
  output logic [VAL_IDX_W-1:0] valIdx,
  output logic coilPulse,
  output logic [15:0] coilAddr,
  output logic coilOn,
  output logic [15:0] baudDiv,
  output logic [3:0] charLen,
  output logic [15:0] tcpPort
);
  core_t cur;
  core_t nxt;

  logic [3:0] pduOff;
  logic [7:0] fcIn;
  logic [15:0] addrIn;
  logic [15:0] qtyIn;
  logic [4:0] bodyIn;
  logic [16:0] endIn;
  logic shortIt;
  logic serBad;
  logic tcpBad;
  logic dropIt;
  logic fcKnown;
  logic [8:0] hdrLen;
  logic [8:0] bodyIdx;
  logic [8:0] dataIdx;
  logic [8:0] lastPos;
  logic [15:0] tcpLen;
  logic [15:0] rxCrc;
  logic [15:0] txCrc;
  logic rxCrcEn;
  logic txCrcEn;
  logic crcClr;

  // Request fields sit at a fixed offset behind the address or header
  assign pduOff = cur.tcp ? MBAP_LEN : RTU_HDR_LEN;
  assign fcIn = cur.rxBuf[pduOff + PDU_FC];
  assign addrIn = {cur.rxBuf[pduOff + PDU_ADDR_HI], cur.rxBuf[pduOff + PDU_ADDR_LO]};
  assign qtyIn = {cur.rxBuf[pduOff + PDU_QTY_HI], cur.rxBuf[pduOff + PDU_QTY_LO]};
  assign bodyIn = cur.rxCnt - {1'b0, pduOff} - (cur.tcp ? 5'h00 : CRC_BYTES);
  assign endIn = {1'b0, addrIn} + {1'b0, qtyIn};
  assign shortIt = (fcIn != FC_EXC_STATUS) && (bodyIn < PDU_REQ_LEN);

  assign serBad = (cur.rxCnt < RTU_MIN_CNT)
    || (rxCrc != CRC_RESIDUE)
    || (cur.rxBuf[RTU_ADDR] == BROADCAST_ID)
    || (cur.rxBuf[RTU_ADDR] != slaveId)
    || (slaveId < SLAVE_ID_MIN)
    || (slaveId > SLAVE_ID_MAX);
  // Unit id takes no part in the decision
  assign tcpBad = (cur.rxCnt < TCP_MIN_CNT)
    || ({cur.rxBuf[MBAP_PROTO_HI], cur.rxBuf[MBAP_PROTO_LO]} != MBAP_PROTO);
  assign dropIt = cur.rxOvf || (cur.tcp ? tcpBad : serBad);

  assign fcKnown = (fcIn == FC_READ_COILS) || (fcIn == FC_READ_INPUTS)
    || (fcIn == FC_READ_HOLD) || (fcIn == FC_READ_INREG)
    || (fcIn == FC_WRITE_COIL) || (fcIn == FC_EXC_STATUS);

  assign hdrLen = {5'h00, pduOff};
  assign bodyIdx = cur.pos - hdrLen;
  assign dataIdx = bodyIdx - RSP_DATA;
  assign lastPos = hdrLen + {1'b0, cur.bodyLen}
    + (cur.tcp ? 9'h000 : {4'h0, CRC_BYTES}) - 9'h001;
  assign tcpLen = {8'h00, cur.bodyLen} + MBAP_UNIT_LEN;

  assign rxCrcEn = (cur.st == ST_RECV) && rxValid && (cur.rxCnt < BUF_BYTES);
  assign txCrcEn = cur.txValid && txReady && (cur.pos < hdrLen + {1'b0, cur.bodyLen});
  assign crcClr = (cur.st == ST_EVAL);

  crc16_rtu u_rx_crc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .crcClr(crcClr),
    .crcEn(rxCrcEn),
    .crcByte(rxData),
    .crcOut(rxCrc)
  );

  crc16_rtu u_tx_crc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .crcClr(crcClr),
    .crcEn(txCrcEn),
    .crcByte(cur.txData),
    .crcOut(txCrc)
  );

  always_comb begin
    logic [7:0] excIn;
    logic [7:0] lenIn;
    logic [15:0] regA;
    logic [7:0] rsp;
    logic needWord;
    excIn = EXC_NONE;
    lenIn = RSP_SHORT_LEN;
    regA = cur.startA + {8'h00, dataIdx[8:1]};
    rsp = 8'h00;
    needWord = 1'b0;
    nxt = cur;
    nxt.coilPulse = 1'b0;

    if (baudLoad) nxt.baudDiv = baud_div(baudSel);

    case (fcIn)
      FC_READ_COILS, FC_READ_INPUTS: begin
        lenIn = RSP_SHORT_LEN + 8'((qtyIn[4:0] + BIT_ROUND) >> BIT_SHIFT);
        if (shortIt || qtyIn == '0 || qtyIn > STATUS_BITS) excIn = EXC_ILL_DATA;
        else if (endIn > {1'b0, STATUS_BITS}) excIn = EXC_ILL_ADDR;
      end
      FC_READ_HOLD, FC_READ_INREG: begin
        lenIn = RSP_SHORT_LEN + {qtyIn[6:0], 1'b0};
        if (shortIt || qtyIn == '0 || qtyIn > REG_QTY_MAX) excIn = EXC_ILL_DATA;
        else if (endIn > REG_COUNT) excIn = EXC_ILL_ADDR;
      end
      FC_WRITE_COIL: begin
        lenIn = COIL_RSP_LEN;
        if (shortIt) excIn = EXC_ILL_DATA;
      end
      FC_EXC_STATUS: begin
        lenIn = RSP_SHORT_LEN;
      end
      default: begin
        excIn = EXC_ILL_FUNC;
      end
    endcase
    if (excIn != EXC_NONE) lenIn = RSP_SHORT_LEN;

    // Reply byte at the current position
    if (cur.pos < hdrLen) begin
      if (!cur.tcp) rsp = cur.rxBuf[RTU_ADDR];
      else if (cur.pos[3:0] == MBAP_LEN_HI) rsp = tcpLen[15:8];
      else if (cur.pos[3:0] == MBAP_LEN_LO) rsp = tcpLen[7:0];
      else rsp = cur.rxBuf[cur.pos[3:0]];
    end else if (bodyIdx == RSP_FC) begin
      rsp = (cur.exc != EXC_NONE) ? (cur.fc | EXC_FLAG) : cur.fc;
    end else if (bodyIdx < {1'b0, cur.bodyLen}) begin
      if (cur.exc != EXC_NONE) rsp = cur.exc;
      else if (cur.fc == FC_WRITE_COIL) rsp = cur.rxBuf[pduOff + bodyIdx[3:0]];
      else if (cur.fc == FC_EXC_STATUS) rsp = excStatus;
      else if (bodyIdx == RSP_COUNT) rsp = cur.bodyLen - RSP_SHORT_LEN;
      else if (cur.fc == FC_READ_COILS || cur.fc == FC_READ_INPUTS) begin
        rsp = dataIdx[0] ? cur.bits[15:8] : cur.bits[7:0];
      end else begin
        rsp = dataIdx[0] ? cur.word[7:0] : cur.word[15:8];
        needWord = !dataIdx[0];
      end
    end else begin
      rsp = (bodyIdx == {1'b0, cur.bodyLen}) ? txCrc[7:0] : txCrc[15:8];
    end

    case (cur.st)
      ST_RECV: begin
        if (rxValid) begin
          if (cur.rxCnt == '0) nxt.tcp = tcpMode;
          if (cur.rxCnt < BUF_BYTES) begin
            nxt.rxBuf[cur.rxCnt[3:0]] = rxData;
            nxt.rxCnt = cur.rxCnt + 5'h01;
          end else begin
            nxt.rxOvf = 1'b1;
          end
        end
        if (rxEnd && (rxValid || cur.rxCnt != '0)) nxt.st = ST_EVAL;
      end
      ST_EVAL: begin
        nxt.rxCnt = '0;
        nxt.rxOvf = 1'b0;
        nxt.st = ST_RECV;
        if (!dropIt) begin
          nxt.st = ST_SEND;
          nxt.fc = fcIn;
          nxt.startA = addrIn;
          nxt.qty = qtyIn[7:0];
          nxt.exc = excIn;
          nxt.bodyLen = lenIn;
          nxt.pos = '0;
          nxt.wordOk = 1'b0;
          // Both bit reads see the same relay image
          nxt.bits = 16'((32'(relayStatus) >> addrIn[4:0])
            & ((32'h1 << qtyIn[4:0]) - 32'h1));
          if (fcIn == FC_WRITE_COIL && excIn == EXC_NONE
              && (qtyIn == COIL_ON || qtyIn == COIL_OFF)) begin
            nxt.coilPulse = 1'b1;
            nxt.coilAddr = addrIn;
            nxt.coilOn = (qtyIn == COIL_ON);
          end
        end
      end
      ST_SEND: begin
        if (!cur.txValid) begin
          if (needWord && !cur.wordOk) nxt.st = ST_FETCH;
          else begin
            nxt.txData = rsp;
            nxt.txValid = 1'b1;
          end
        end else if (txReady) begin
          nxt.txValid = 1'b0;
          nxt.pos = cur.pos + 9'h001;
          // Word stays valid only between its high and low byte
          nxt.wordOk = cur.wordOk && needWord;
          if (cur.pos == lastPos) nxt.st = ST_RECV;
        end
      end
      ST_FETCH: begin
        nxt.valIdx = regA[VAL_IDX_W:1];
        nxt.halfHi = regA[0];
        nxt.st = ST_LATCH;
      end
      ST_LATCH: begin
        nxt.word = cur.halfHi ? valWord[31:16] : valWord[15:0];
        nxt.wordOk = 1'b1;
        nxt.st = ST_SEND;
      end
      default: begin
        nxt = CORE_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) cur <= CORE_RESET;
    else cur <= nxt;
  end

  assign txData = cur.txData;
  assign txValid = cur.txValid;
  assign valIdx = cur.valIdx;
  assign coilPulse = cur.coilPulse;
  assign coilAddr = cur.coilAddr;
  assign coilOn = cur.coilOn;
  assign baudDiv = cur.baudDiv;
  assign charLen = cur.charLen;
  assign tcpPort = cur.port;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_baud_default: assert property (
    $fell(sys_rst) |-> baudDiv == BAUD_DIV_DEFAULT)
    else $error("baud divisor not at 9600 after reset");
  a_tcp_port: assert property (
    tcpPort == TCP_PORT && charLen == CHAR_LEN)
    else $error("port or character length wrong");
  a_drop_foreign: assert property (
    cur.st == ST_EVAL && !cur.tcp && cur.rxBuf[RTU_ADDR] != slaveId
    |=> cur.st == ST_RECV && !txValid [*2])
    else $error("frame for other id answered");
  a_no_broadcast: assert property (
    cur.st == ST_EVAL && !cur.tcp && cur.rxBuf[RTU_ADDR] == BROADCAST_ID
    |=> cur.st == ST_RECV)
    else $error("broadcast frame acted on");
  a_crc_drop: assert property (
    cur.st == ST_EVAL && !cur.tcp && rxCrc != CRC_RESIDUE |=> cur.st == ST_RECV)
    else $error("bad check frame accepted");
  a_unit_ignored: assert property (
    cur.st == ST_EVAL && cur.tcp && !cur.rxOvf && cur.rxCnt >= TCP_MIN_CNT
    && {cur.rxBuf[MBAP_PROTO_HI], cur.rxBuf[MBAP_PROTO_LO]} == MBAP_PROTO
    |=> cur.st == ST_SEND ##1 txValid)
    else $error("valid tcp frame not answered");
  a_illegal_fc: assert property (
    cur.st == ST_EVAL && !dropIt && !fcKnown |=> cur.exc == EXC_ILL_FUNC)
    else $error("unsupported code not rejected");
  a_exc_fc: assert property (
    txValid && cur.pos == hdrLen && cur.exc != EXC_NONE |-> txData == (cur.fc | EXC_FLAG))
    else $error("exception function byte wrong");
  a_bit_count: assert property (
    txValid && cur.pos == hdrLen + RSP_COUNT && cur.exc == EXC_NONE
    && (cur.fc == FC_READ_COILS || cur.fc == FC_READ_INPUTS)
    |-> txData == 8'((cur.qty[4:0] + BIT_ROUND) >> BIT_SHIFT))
    else $error("bit read byte count wrong");
  a_reg_count: assert property (
    txValid && cur.pos == hdrLen + RSP_COUNT && cur.exc == EXC_NONE
    && (cur.fc == FC_READ_HOLD || cur.fc == FC_READ_INREG)
    |-> txData == {cur.qty[6:0], 1'b0})
    else $error("register byte count wrong");
  a_tid_echo: assert property (
    txValid && cur.tcp && cur.pos == RSP_FC |-> txData == cur.rxBuf[0])
    else $error("transaction id not echoed");
  a_coil_legal: assert property (
    coilPulse |-> $past(qtyIn) == COIL_ON || $past(qtyIn) == COIL_OFF)
    else $error("coil action on illegal value");
  a_tx_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte dropped under stall");

  c_bit_read: cover property (
    txValid && txReady && cur.pos == lastPos && cur.fc == FC_READ_INPUTS);
  c_reg_read: cover property (
    txValid && txReady && cur.pos == lastPos && cur.fc == FC_READ_HOLD && cur.tcp);
  c_exception: cover property (
    txValid && txReady && cur.pos == lastPos && cur.exc == EXC_ILL_FUNC);
  c_coil_write: cover property (coilPulse && coilOn);
endmodule : modbus_request_handler
`default_nettype wire
